// ### design/mid_decoder.sv
// Decode and execute core of the 8-bit controller: fetch, ALU ops, skips, returns.
// Assumes program memory answers pmem_addr_o within one clock and the register
// file answers reg_raddr_o combinationally; stack storage lives outside.
`timescale 1ns/1ps
`include "mid_params.svh"
module mid_decoder import mid_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [1:0] cycle_length_option_i,
   input wire logic [12:0] instr_i,
   output logic [9:0] pmem_addr_o,
   output logic [5:0] reg_raddr_o,
   input wire logic [7:0] reg_rdata_i,
   output mid_reg_wr_t reg_wr_o,
   output logic [3:0] ioc_rsel_o,
   input wire logic [7:0] ioc_rdata_i,
   output mid_ioc_wr_t ioc_wr_o,
   input wire logic [9:0] stack_top_i,
   output logic stack_push_o,
   output logic [9:0] stack_pc_o,
   output logic stack_pop_o,
   input wire logic tbl_high_i,
   input wire logic wake_i,
   output logic icyc_o,
   output logic [7:0] acc_o,
   output mid_flags_t flags_o,
   output logic [7:0] ctrl_o,
   output logic gie_o,
   output logic timeout_o,
   output logic pwr_down_o,
   output logic sleep_o,
   output logic wdt_clear_o
);
   mid_state_t st_ff;
   mid_state_t nxt_st;

   logic [12:0] ins;
   logic [5:0] code;
   logic [7:0] rd;
   logic [7:0] operand;
   logic [7:0] bit_mask;
   logic [7:0] bit_res;
   logic bit_val;
   mid_alu_op_t alu_op;
   mid_flcls_t fcls;
   logic use_lit;
   logic wr_r;
   logic wr_a;
   logic zskip;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;

   // Register write-back; a write to the program counter costs an extra cycle
   function automatic mid_state_t put_reg(mid_state_t s, logic [5:0] a, logic [7:0] v);
      mid_state_t r;
      r = s;
      if (a == `MID_PC_ADDR) begin
         r.pc = {s.pc[9:8], v};
         r.phase = MID_EXTRA;
      end else begin
         r.reg_wr.we = 1'b1;
         r.reg_wr.addr = a;
         r.reg_wr.data = v;
      end
      return r;
   endfunction

   function automatic logic ioc_ok(logic [3:0] sel);
      logic [15:0] m;
      m = `MID_IOC_VALID;
      return m[sel];
   endfunction

   mid_cycle_div u_div (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .run_i(!st_ff.sleeping),
      .option_i(cycle_length_option_i),
      .stb_o(icyc_o)
   );

   mid_alu u_alu (
      .op_i(alu_op),
      .a_i(st_ff.acc),
      .b_i(operand),
      .cin_i(st_ff.flags.c),
      .dcin_i(st_ff.flags.dc),
      .res_o(alu_res),
      .c_o(alu_c),
      .dc_o(alu_dc)
   );

   assign ins = instr_i;
   assign code = ins[`MID_CODE_MSB:`MID_CODE_LSB];
   assign reg_raddr_o = ins[`MID_RADDR_MSB:0];
   assign ioc_rsel_o = ins[3:0];
   // Table reads fetch the word addressed by the accumulator on the current page
   assign pmem_addr_o = (st_ff.phase == MID_TBL) ? {st_ff.pc[9:8], st_ff.acc} : st_ff.pc;
   assign rd = (reg_raddr_o == `MID_PC_ADDR) ? st_ff.pc[7:0] : reg_rdata_i;
   assign operand = use_lit ? ins[`MID_LIT_MSB:0] : rd;
   assign bit_mask = 8'h01 << ins[`MID_BIT_MSB:`MID_BIT_LSB];
   assign bit_res = ins[9] ? (rd | bit_mask) : (rd & ~bit_mask);
   assign bit_val = |(rd & bit_mask);

   // Data path decode; control opcodes are handled in the execute block
   always_comb begin
      alu_op = MID_ALU_PASS_A;
      fcls = MID_FL_NONE;
      use_lit = 1'b0;
      wr_r = 1'b0;
      wr_a = 1'b0;
      zskip = 1'b0;
      if (!ins[12] && !ins[11]) begin
         if (ins == `MID_OP_DAA) begin
            alu_op = MID_ALU_DAA;
            wr_a = 1'b1;
            fcls = MID_FL_C;
         end else if (code == 6'h01) begin
            wr_r = 1'b1;
         end else if (ins == `MID_OP_CLRA) begin
            alu_op = MID_ALU_CLR;
            wr_a = 1'b1;
            fcls = MID_FL_Z;
         end else if (code == 6'h03) begin
            alu_op = MID_ALU_CLR;
            wr_r = 1'b1;
            fcls = MID_FL_Z;
         end else if (code >= 6'h04) begin
            wr_r = code[0];
            wr_a = !code[0];
            fcls = MID_FL_Z;
            case (code[5:1])
               5'h02: begin
                  alu_op = MID_ALU_SUB;
                  fcls = MID_FL_ZCDC;
               end
               5'h03: alu_op = MID_ALU_DEC;
               5'h04: alu_op = MID_ALU_OR;
               5'h05: alu_op = MID_ALU_AND;
               5'h06: alu_op = MID_ALU_XOR;
               5'h07: begin
                  alu_op = MID_ALU_ADD;
                  fcls = MID_FL_ZCDC;
               end
               5'h08: alu_op = MID_ALU_PASS_B;
               5'h09: alu_op = MID_ALU_COM;
               5'h0a: alu_op = MID_ALU_INC;
               5'h0b: begin
                  alu_op = MID_ALU_DEC;
                  fcls = MID_FL_NONE;
                  zskip = 1'b1;
               end
               5'h0c: begin
                  alu_op = MID_ALU_RRC;
                  fcls = code[0] ? MID_FL_NONE : MID_FL_C;
                  wr_r = 1'b0;
                  wr_a = !code[0];
               end
               5'h0f: begin
                  alu_op = MID_ALU_INC;
                  fcls = MID_FL_NONE;
                  zskip = 1'b1;
               end
               default: begin
                  wr_r = 1'b0;
                  wr_a = 1'b0;
                  fcls = MID_FL_NONE;
               end
            endcase
         end
      end else if (ins[12] && ins[11] && ins[10:8] != 3'h4 && ins[10:8] != 3'h6) begin
         use_lit = 1'b1;
         wr_a = 1'b1;
         fcls = MID_FL_Z;
         case (ins[10:8])
            3'h0: begin
               alu_op = MID_ALU_PASS_B;
               fcls = MID_FL_NONE;
            end
            3'h1: alu_op = MID_ALU_OR;
            3'h2: alu_op = MID_ALU_AND;
            3'h3: alu_op = MID_ALU_XOR;
            3'h5: begin
               alu_op = MID_ALU_SUB;
               fcls = MID_FL_ZCDC;
            end
            default: begin
               alu_op = MID_ALU_ADD;
               fcls = MID_FL_ZCDC;
            end
         endcase
      end
   end

   // Execute at each instruction cycle strobe
   always_comb begin
      nxt_st = st_ff;
      nxt_st.reg_wr.we = 1'b0;
      nxt_st.ioc_wr.we = 1'b0;
      nxt_st.wdt_clr = 1'b0;
      nxt_st.push = 1'b0;
      nxt_st.pop = 1'b0;
      if (st_ff.sleeping && wake_i) begin
         nxt_st.sleeping = 1'b0;
      end
      if (icyc_o) begin
         case (st_ff.phase)
            MID_EXTRA: nxt_st.phase = MID_EXEC;
            MID_SKIP: begin
               nxt_st.pc = st_ff.pc + 10'h001;
               nxt_st.phase = MID_EXEC;
            end
            MID_TBL: begin
               nxt_st.phase = MID_EXEC;
               nxt_st = put_reg(nxt_st, st_ff.tbl_dst,
                  tbl_high_i ? {3'h0, ins[12:8]} : ins[7:0]);
            end
            default: begin
               nxt_st.pc = st_ff.pc + 10'h001;
               if (wr_a) begin
                  nxt_st.acc = alu_res;
               end
               if (wr_r) begin
                  nxt_st = put_reg(nxt_st, reg_raddr_o, alu_res);
               end
               if (fcls == MID_FL_Z || fcls == MID_FL_ZCDC) begin
                  nxt_st.flags.z = (alu_res == 8'h00);
               end
               if (fcls == MID_FL_ZCDC || fcls == MID_FL_C) begin
                  nxt_st.flags.c = alu_c;
               end
               if (fcls == MID_FL_ZCDC) begin
                  nxt_st.flags.dc = alu_dc;
               end
               if (zskip && alu_res == 8'h00) begin
                  nxt_st.phase = MID_SKIP;
               end
               if (!ins[12] && ins[11]) begin
                  if (!ins[10]) begin
                     nxt_st = put_reg(nxt_st, reg_raddr_o, bit_res);
                  end else if (bit_val == ins[9]) begin
                     nxt_st.phase = MID_SKIP;
                  end
               end else if (ins[12] && !ins[11]) begin
                  nxt_st.pc = ins[`MID_JMP_MSB:0];
                  nxt_st.phase = MID_EXTRA;
                  if (!ins[10]) begin
                     nxt_st.push = 1'b1;
                     nxt_st.push_pc = st_ff.pc + 10'h001;
                  end
               end else if (ins[12:8] == 5'h1c) begin
                  nxt_st.acc = ins[`MID_LIT_MSB:0];
                  nxt_st.pc = stack_top_i;
                  nxt_st.pop = 1'b1;
                  nxt_st.phase = MID_EXTRA;
               end else if (ins[12:6] == 7'h7b) begin
                  nxt_st.tbl_dst = reg_raddr_o;
                  nxt_st.phase = MID_TBL;
               end else if (ins[12:6] == 7'h00) begin
                  if (ins == `MID_OP_CONTW) begin
                     nxt_st.ctrl = st_ff.acc;
                  end else if (ins == `MID_OP_CONTR) begin
                     nxt_st.acc = st_ff.ctrl;
                  end else if (ins == `MID_OP_SLEEP) begin
                     nxt_st.wdt_clr = 1'b1;
                     nxt_st.sleeping = 1'b1;
                     nxt_st.timeout = 1'b1;
                     nxt_st.pwr_down = 1'b0;
                  end else if (ins == `MID_OP_WDTCLR) begin
                     nxt_st.wdt_clr = 1'b1;
                     nxt_st.timeout = 1'b1;
                     nxt_st.pwr_down = 1'b1;
                  end else if (ins == `MID_OP_IRQ_EN) begin
                     nxt_st.gie = 1'b1;
                  end else if (ins == `MID_OP_IRQ_DIS) begin
                     nxt_st.gie = 1'b0;
                  end else if (ins == `MID_OP_RET || ins == `MID_OP_RETURN_IRQ_INSTR) begin
                     nxt_st.pc = stack_top_i;
                     nxt_st.pop = 1'b1;
                     nxt_st.phase = MID_EXTRA;
                     if (ins == `MID_OP_RETURN_IRQ_INSTR) begin
                        nxt_st.gie = 1'b1;
                     end
                  end else if (ins[5:4] == 2'b00 && ioc_ok(ins[3:0])) begin
                     nxt_st.ioc_wr.we = 1'b1;
                     nxt_st.ioc_wr.sel = ins[3:0];
                     nxt_st.ioc_wr.data = st_ff.acc;
                  end else if (ins[5:4] == 2'b01 && ioc_ok(ins[3:0])) begin
                     nxt_st.acc = ioc_rdata_i;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         st_ff <= '0;
         st_ff.pc <= `MID_PC_RST;
         st_ff.acc <= `MID_ACC_RST;
         st_ff.ctrl <= `MID_CTRL_RST;
         st_ff.timeout <= `MID_TO_RST;
         st_ff.pwr_down <= `MID_PD_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_wr_o = st_ff.reg_wr;
   assign ioc_wr_o = st_ff.ioc_wr;
   assign stack_push_o = st_ff.push;
   assign stack_pc_o = st_ff.push_pc;
   assign stack_pop_o = st_ff.pop;
   assign acc_o = st_ff.acc;
   assign flags_o = st_ff.flags;
   assign ctrl_o = st_ff.ctrl;
   assign gie_o = st_ff.gie;
   assign timeout_o = st_ff.timeout;
   assign pwr_down_o = st_ff.pwr_down;
   assign sleep_o = st_ff.sleeping;
   assign wdt_clear_o = st_ff.wdt_clr;
endmodule // mid_decoder

// ### design/mid_params.svh
// Constants of the instruction decoder: opcodes, field positions, reset values, cycle counts.
// Assumes inclusion by the package, the design modules and the checker only.
// How it works
// - Instruction words are 13 bits: an operation code plus operand fields.
// - Ordinary instructions finish in one instruction cycle.
// - Any instruction writing the program counter register takes two instruction cycles; a table read into it takes three.
// - Table read, returns and true conditional skips take two instruction cycles.
// - Cycle option 01 gives two oscillator clocks per cycle, 00 gives four.
// - Every register bit can be set, cleared or tested by bit instructions.
// - I/O control registers are reached only by their own move instructions, not as general registers.
// - Literal fields decode as 8-bit or 10-bit constants, by instruction.
// - Control register moves only address controls 5 to 7 and A to F.
// - Sleep clears watchdog, stops clock, sets timeout, clears power-down; watchdog clear clears and sets both.
// - 0010 sets, 0011 clears interrupt enable; 0013 returns and sets it.
// - Rotate right to accumulator shifts register down, bit 0 to carry, carry to 7.
// - Decrement-and-skip stores result, skips when zero, leaves flags alone.
// - Period option 00 is 4 clocks, 01 is 2, 10 is 8, 11 is 16.
`ifndef MID_PARAMS_SVH
`define MID_PARAMS_SVH

`define MID_OP_NOP 13'h0000
`define MID_OP_DAA 13'h0001
`define MID_OP_CONTW 13'h0002
`define MID_OP_SLEEP 13'h0003
`define MID_OP_WDTCLR 13'h0004
`define MID_OP_IRQ_EN 13'h0010
`define MID_OP_IRQ_DIS 13'h0011
`define MID_OP_RET 13'h0012
`define MID_OP_RETURN_IRQ_INSTR 13'h0013
`define MID_OP_CONTR 13'h0014
`define MID_OP_CLRA 13'h0080

`define MID_CODE_MSB 11
`define MID_CODE_LSB 6
`define MID_RADDR_MSB 5
`define MID_BIT_MSB 8
`define MID_BIT_LSB 6
`define MID_LIT_MSB 7
`define MID_JMP_MSB 9

`define MID_PC_ADDR 6'h02
`define MID_IOC_VALID 16'hfce0

`define MID_PC_RST 10'h000
`define MID_ACC_RST 8'h00
`define MID_CTRL_RST 8'h00
`define MID_TO_RST 1'b1
`define MID_PD_RST 1'b1

`define MID_TC_4CLK 4'h3
`define MID_TC_2CLK 4'h1
`define MID_TC_8CLK 4'h7
`define MID_TC_16CLK 4'hf

`endif

// ### design/mid_pkg.sv
// Types shared by the instruction decoder modules.
// Assumes mid_params.svh sits beside it.
`include "mid_params.svh"
package mid_pkg;
   typedef enum logic [1:0] {
      MID_EXEC = 2'b00,
      MID_EXTRA = 2'b01,
      MID_SKIP = 2'b11,
      MID_TBL = 2'b10
   } mid_phase_t;

   typedef enum logic [3:0] {
      MID_ALU_PASS_A, MID_ALU_PASS_B, MID_ALU_CLR, MID_ALU_ADD, MID_ALU_SUB,
      MID_ALU_OR, MID_ALU_AND, MID_ALU_XOR, MID_ALU_COM, MID_ALU_INC,
      MID_ALU_DEC, MID_ALU_RRC, MID_ALU_DAA
   } mid_alu_op_t;

   typedef enum logic [1:0] {MID_FL_NONE, MID_FL_Z, MID_FL_ZCDC, MID_FL_C} mid_flcls_t;

   typedef struct packed {logic z; logic c; logic dc;} mid_flags_t;
   typedef struct packed {logic we; logic [5:0] addr; logic [7:0] data;} mid_reg_wr_t;
   typedef struct packed {logic we; logic [3:0] sel; logic [7:0] data;} mid_ioc_wr_t;
   typedef struct packed {logic [3:0] cnt;} mid_div_t;

   typedef struct packed {
      mid_phase_t phase;
      logic [9:0] pc;
      logic [7:0] acc;
      mid_flags_t flags;
      logic gie;
      logic timeout;
      logic pwr_down;
      logic sleeping;
      logic [7:0] ctrl;
      logic [5:0] tbl_dst;
      mid_reg_wr_t reg_wr;
      mid_ioc_wr_t ioc_wr;
      logic wdt_clr;
      logic push;
      logic pop;
      logic [9:0] push_pc;
   } mid_state_t;
endpackage

// ### design/mid_cycle_div.sv
// Instruction cycle divider: one-cycle strobe every 2, 4, 8 or 16 oscillator clocks.
// Assumes the oscillator is clock_i; run_i low freezes the count, as in sleep.
`timescale 1ns/1ps
`include "mid_params.svh"
module mid_cycle_div import mid_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic run_i,
   input wire logic [1:0] option_i,
   output logic stb_o
);
   mid_div_t st_ff;
   mid_div_t nxt_st;
   logic [3:0] term;

   always_comb begin
      case (option_i)
         2'b00: term = `MID_TC_4CLK;
         2'b01: term = `MID_TC_2CLK;
         2'b10: term = `MID_TC_8CLK;
         default: term = `MID_TC_16CLK;
      endcase
      stb_o = run_i && (st_ff.cnt >= term);
      nxt_st = st_ff;
      if (stb_o) begin
         nxt_st.cnt = 4'h0;
      end else if (run_i) begin
         nxt_st.cnt = st_ff.cnt + 4'h1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end
endmodule // mid_cycle_div

// ### design/mid_alu.sv
// Combinational 8-bit arithmetic and logic unit of the decoder.
// Assumes the caller decides which flags to keep; zero is tested by the caller.
`timescale 1ns/1ps
module mid_alu import mid_pkg::*; (
   input mid_alu_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic cin_i,
   input wire logic dcin_i,
   output logic [7:0] res_o,
   output logic c_o,
   output logic dc_o
);
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] adj;

   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      adj = 8'h00;
      res_o = a_i;
      c_o = cin_i;
      dc_o = dcin_i;
      case (op_i)
         MID_ALU_PASS_B: res_o = b_i;
         MID_ALU_CLR: res_o = 8'h00;
         MID_ALU_ADD: begin
            sum = {1'b0, a_i} + {1'b0, b_i};
            nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
            res_o = sum[7:0];
            c_o = sum[8];
            dc_o = nib[4];
         end
         MID_ALU_SUB: begin
            // Carry high means no borrow
            sum = {1'b0, b_i} + {1'b0, ~a_i} + 9'h001;
            nib = {1'b0, b_i[3:0]} + {1'b0, ~a_i[3:0]} + 5'h01;
            res_o = sum[7:0];
            c_o = sum[8];
            dc_o = nib[4];
         end
         MID_ALU_OR: res_o = a_i | b_i;
         MID_ALU_AND: res_o = a_i & b_i;
         MID_ALU_XOR: res_o = a_i ^ b_i;
         MID_ALU_COM: res_o = ~b_i;
         MID_ALU_INC: res_o = b_i + 8'h01;
         MID_ALU_DEC: res_o = b_i - 8'h01;
         MID_ALU_RRC: begin
            res_o = {cin_i, b_i[7:1]};
            c_o = b_i[0];
         end
         MID_ALU_DAA: begin
            adj[3:0] = (a_i[3:0] > 4'h9 || dcin_i) ? 4'h6 : 4'h0;
            adj[7:4] = (a_i > 8'h99 || cin_i) ? 4'h6 : 4'h0;
            sum = {1'b0, a_i} + {1'b0, adj};
            res_o = sum[7:0];
            c_o = sum[8] | (adj[7:4] != 4'h0);
         end
         default: res_o = a_i;
      endcase
   end
endmodule // mid_alu

// ### verification/mid_decoder_asserts.sv
// Port checks of the decoder: strobe spacing, sleep, watchdog clear, interrupt enable,
// returns, control register writes and flagless skips.
// Assumes it is bound to mid_decoder; every check is idle while reset is low.
`timescale 1ns/1ps
`include "mid_params.svh"
module mid_decoder_asserts import mid_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic [1:0] cycle_length_option_i,
   input wire logic [12:0] instr_i,
   input wire logic [9:0] stack_top_i,
   input wire logic [9:0] pmem_addr_o,
   input mid_ioc_wr_t ioc_wr_o,
   input mid_flags_t flags_o,
   input wire logic stack_pop_o,
   input wire logic icyc_o,
   input wire logic gie_o,
   input wire logic timeout_o,
   input wire logic pwr_down_o,
   input wire logic sleep_o,
   input wire logic wdt_clear_o
);
   localparam logic [15:0] IocOk = `MID_IOC_VALID;
   logic [3:0] gap_ff;
   logic seen_ff;
   logic [3:0] gap_exp;

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);

   always_comb begin
      case (cycle_length_option_i)
         2'b00: gap_exp = 4'h3;
         2'b01: gap_exp = 4'h1;
         2'b10: gap_exp = 4'h7;
         default: gap_exp = 4'hf;
      endcase
   end

   // A 16-clock period is too long to unroll, so the gap is counted here
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         gap_ff <= 4'h0;
         seen_ff <= 1'b0;
      end else begin
         gap_ff <= icyc_o ? 4'h0 : gap_ff + 4'h1;
         seen_ff <= (seen_ff | icyc_o) & ~sleep_o;
      end
   end

   sequence s_taken(logic [12:0] op);
      icyc_o && !sleep_o && instr_i == op;
   endsequence
   sequence s_ret;
      icyc_o && (instr_i == `MID_OP_RET || instr_i == `MID_OP_RETURN_IRQ_INSTR);
   endsequence

   a_cycle_gap: assert property (icyc_o && seen_ff |-> gap_ff == gap_exp)
      else $error("instruction strobe spacing wrong");
   a_sleep_quiet: assert property (sleep_o |-> !icyc_o)
      else $error("strobe while asleep");
   a_sleep_entry: assert property (s_taken(`MID_OP_SLEEP) |=>
      sleep_o && wdt_clear_o && timeout_o && !pwr_down_o) else $error("sleep entry wrong");
   a_wdt_clear: assert property (s_taken(`MID_OP_WDTCLR) |=>
      wdt_clear_o && timeout_o && pwr_down_o && !sleep_o) else $error("watchdog clear wrong");
   a_irq_on: assert property (s_taken(`MID_OP_IRQ_EN) |=> gie_o)
      else $error("interrupt enable not set");
   a_irq_off: assert property (s_taken(`MID_OP_IRQ_DIS) |=> !gie_o)
      else $error("interrupt enable not cleared");
   a_ret_pop: assert property (s_ret |=> stack_pop_o && pmem_addr_o == $past(stack_top_i))
      else $error("return did not load stack top");
   a_return_irq_instr_gie: assert property (s_taken(`MID_OP_RETURN_IRQ_INSTR) |=> gie_o)
      else $error("return from interrupt left enable low");
   a_ioc_valid: assert property (ioc_wr_o.we |-> IocOk[ioc_wr_o.sel]
      && $past(instr_i[3:0]) == ioc_wr_o.sel) else $error("control write to bad select");
   a_skip_flags: assert property (icyc_o && instr_i[12:7] inside {6'b001011, 6'b001111}
      |=> $stable(flags_o)) else $error("skip counter changed flags");
endmodule // mid_decoder_asserts

bind mid_decoder mid_decoder_asserts chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
   .cycle_length_option_i(cycle_length_option_i), .instr_i(instr_i),
   .stack_top_i(stack_top_i), .pmem_addr_o(pmem_addr_o), .ioc_wr_o(ioc_wr_o),
   .flags_o(flags_o), .stack_pop_o(stack_pop_o), .icyc_o(icyc_o), .gie_o(gie_o),
   .timeout_o(timeout_o), .pwr_down_o(pwr_down_o), .sleep_o(sleep_o),
   .wdt_clear_o(wdt_clear_o));

// ### verification/mid_pmem_model.sv
// Program memory model: 13-bit words read with no wait state.
// Assumes the bench loads every word before reset is released.
`timescale 1ns/1ps
module mid_pmem_model (
   input wire logic [9:0] addr_i,
   output logic [12:0] instr_o
);
   logic [12:0] mem [1024];
   assign instr_o = mem[addr_i];
endmodule // mid_pmem_model

// ### verification/test_mid_decoder.sv
// Bench of the decoder: a table of single instructions, then skips, program counter
// writes, returns, control registers, sleep and the four period options.
// Assumes the program memory model and the bound checker.
`timescale 1ns/1ps
module test_mid_decoder;
   import mid_pkg::*;
   typedef struct packed {
      logic [7:0] k; logic [12:0] op; logic [7:0] rd; logic [7:0] acc;
      logic [2:0] fl; logic [2:0] fm; logic we; logic [7:0] wd;
   } mid_row_t;
   typedef struct packed {logic [12:0] op; logic [7:0] rd; logic sk;} mid_skip_t;
   mid_row_t rows [20] = '{
      '{8'h0f,13'h0385,8'h01,8'h10,3'h1,3'h7,1'b0,8'h00},
      '{8'hf0,13'h03c5,8'h10,8'hf0,3'h6,3'h7,1'b1,8'h00},
      '{8'h00,13'h0605,8'h03,8'h81,3'h2,3'h2,1'b0,8'h00},
      '{8'h05,13'h0105,8'h05,8'h00,3'h6,3'h6,1'b0,8'h00},
      '{8'h00,13'h0185,8'h01,8'h00,3'h4,3'h4,1'b0,8'h00},
      '{8'h0f,13'h0205,8'hf0,8'hff,3'h0,3'h4,1'b0,8'h00},
      '{8'h0f,13'h02c5,8'hf0,8'h0f,3'h4,3'h4,1'b1,8'h00},
      '{8'hff,13'h0305,8'hff,8'h00,3'h4,3'h4,1'b0,8'h00},
      '{8'h00,13'h0405,8'h5a,8'h5a,3'h0,3'h4,1'b0,8'h00},
      '{8'h00,13'h0485,8'hff,8'h00,3'h4,3'h4,1'b0,8'h00},
      '{8'h12,13'h00e5,8'h77,8'h12,3'h4,3'h4,1'b1,8'h00},
      '{8'h33,13'h007f,8'h00,8'h33,3'h0,3'h0,1'b1,8'h33},
      '{8'h00,13'h0bc5,8'h00,8'h00,3'h0,3'h0,1'b1,8'h80},
      '{8'h00,13'h0805,8'hff,8'h00,3'h0,3'h0,1'b1,8'hfe},
      '{8'h03,13'h1d05,8'h00,8'h02,3'h2,3'h2,1'b0,8'h00},
      '{8'h01,13'h1fff,8'h00,8'h00,3'h7,3'h7,1'b0,8'h00},
      '{8'h5c,13'h0002,8'h00,8'h5c,3'h0,3'h0,1'b0,8'h00},
      '{8'h00,13'h0014,8'h00,8'h5c,3'h0,3'h0,1'b0,8'h00},
      '{8'h55,13'h0080,8'h00,8'h00,3'h4,3'h4,1'b0,8'h00},
      '{8'h12,13'h0001,8'h00,8'h78,3'h2,3'h2,1'b0,8'h00}};
   mid_skip_t skips [7] = '{'{13'h05c5,8'h01,1'b1}, '{13'h0585,8'h01,1'b1},
      '{13'h07c5,8'hff,1'b1}, '{13'h0785,8'hff,1'b1}, '{13'h0cc5,8'h00,1'b1},
      '{13'h0ec5,8'h08,1'b1}, '{13'h05c5,8'h02,1'b0}};
   int terms [4] = '{4, 2, 8, 16};
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic [1:0] opt = 2'b01;
   logic [7:0] rd = 8'h00;
   logic [7:0] iord = 8'h00;
   logic [9:0] top = 10'h000;
   logic wake = 1'b0;
   logic tbh = 1'b0;
   logic [12:0] instr;
   logic [9:0] pa, spc;
   mid_reg_wr_t wr;
   mid_ioc_wr_t iw;
   mid_flags_t fl;
   logic icyc, pop, gie, tout, pdn, slp, wdc, psh;
   logic [7:0] acc, ctrl;
   int error_cnt = 0;
   int tests_run = 0;
   int pp = 0;
   int cyc = 0;
   int n;

   mid_pmem_model pm (.addr_i(pa), .instr_o(instr));
   mid_decoder dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .cycle_length_option_i(opt),
      .instr_i(instr), .pmem_addr_o(pa), .reg_raddr_o(), .reg_rdata_i(rd), .reg_wr_o(wr),
      .ioc_rsel_o(), .ioc_rdata_i(iord), .ioc_wr_o(iw), .stack_top_i(top),
      .stack_push_o(psh), .stack_pc_o(spc), .stack_pop_o(pop), .tbl_high_i(tbh), .wake_i(wake),
      .icyc_o(icyc), .acc_o(acc), .flags_o(fl), .ctrl_o(ctrl), .gie_o(gie),
      .timeout_o(tout), .pwr_down_o(pdn), .sleep_o(slp), .wdt_clear_o(wdc));

   initial forever #20 clock_i = ~clock_i;

   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Returns one falling edge after the strobe, when that instruction's results show
   task automatic step;
      do @(negedge clock_i); while (icyc !== 1'b1);
      @(negedge clock_i);
   endtask
   task automatic put(input logic [12:0] w);
      pm.mem[pp] = w;
      pp++;
   endtask
   task end_sim;
      if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   always @(posedge clock_i) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         end_sim();
      end
   end

   initial begin
      for (int i = 0; i < 1024; i++) pm.mem[i] = 13'h0000;
      foreach (rows[i]) begin
         put({5'h18, rows[i].k});
         put(rows[i].op);
      end
      foreach (skips[i]) begin
         put(skips[i].op);
         put(13'h1877);
         put({5'h18, 8'h10 + 8'(i)});
      end
      put(13'h1880);
      put(13'h0042);
      put(13'h1899);
      pp = 'h80;
      put(13'h1844);
      put(13'h0012);
      pp = 'h100;
      put(13'h1866);
      put(13'h0010);
      put(13'h0011);
      put(13'h0013);
      pp = 'h181;
      put(13'h0004);
      put(13'h183c);
      for (int s = 5; s < 16; s++) put(13'(s));
      put(13'h0016);
      put(13'h0019);
      put(13'h0003);
      put(13'h1821);
      put(13'h1ec5);
      put(13'h1ec5);
      put(13'h11a0);
      pm.mem['h121] = 13'h1a5c;
      repeat (12) @(negedge clock_i);
      rst_b_i = 1'b1;
      foreach (rows[i]) begin
         step();
         rd = rows[i].rd;
         step();
         check(acc, rows[i].acc);
         check(fl & rows[i].fm, rows[i].fl & rows[i].fm);
         check(wr.we, rows[i].we);
         if (rows[i].we) check({wr.addr, wr.data}, {rows[i].op[5:0], rows[i].wd});
      end
      foreach (skips[i]) begin
         rd = skips[i].rd;
         step();
         step();
         check(acc === 8'h77, !skips[i].sk);
         step();
         check(acc, 8'h10 + 8'(i));
      end
      step();
      step();
      step();
      check(acc, 8'h80);
      step();
      check(acc, 8'h44);
      top = 10'h100;
      step();
      check(pop, 1'b1);
      step();
      check(acc, 8'h44);
      step();
      check(acc, 8'h66);
      top = 10'h180;
      for (int i = 0; i < 3; i++) begin
         step();
         check(gie, i != 1);
      end
      step();
      step();
      step();
      check({wdc, tout, pdn}, 3'b111);
      step();
      for (int s = 5; s < 16; s++) begin
         step();
         check(iw.we, s != 8 && s != 9);
         if (iw.we) check({iw.sel, iw.data}, {4'(s), 8'h3c});
      end
      iord = 8'ha5;
      step();
      check(acc, 8'ha5);
      iord = 8'hc3;
      step();
      check(acc, 8'ha5);
      step();
      check({slp, wdc, tout, pdn}, 4'b1110);
      repeat (20) @(negedge clock_i);
      check({slp, icyc}, 2'b10);
      wake = 1'b1;
      step();
      wake = 1'b0;
      check(acc, 8'h21);
      step();
      step();
      check({wr.we, wr.addr, wr.data}, {1'b1, 6'h05, 8'h5c});
      tbh = 1'b1;
      step();
      step();
      check({wr.we, wr.addr, wr.data}, {1'b1, 6'h05, 8'h1a});
      step();
      check({psh, spc, pa}, {1'b1, 10'h195, 10'h1a0});
      for (int o = 0; o < 4; o++) begin
         rst_b_i = 1'b0;
         opt = 2'(o);
         repeat (2) @(negedge clock_i);
         if (o == 0) check({acc, ctrl, gie, tout, pdn, slp}, {16'h0000, 4'b0110});
         rst_b_i = 1'b1;
         do @(negedge clock_i); while (icyc !== 1'b1);
         n = 0;
         do begin
            @(negedge clock_i);
            n++;
         end while (icyc !== 1'b1);
         check(n, terms[o]);
      end
      end_sim();
   end
endmodule // test_mid_decoder
